// >>> src/reasm_consts.svh
`ifndef REASM_CONSTS_SVH
`define REASM_CONSTS_SVH
// Register byte offsets.
`define OFS_MODE 8'h00
`define OFS_THRESH 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0C
`define OFS_CBR_DROP 8'h10
`define OFS_POP 8'h14
`define OFS_LOOKUP 8'h18
`define OFS_AGE 8'h1C
`define OFS_VP_FILTER 8'h20
// Mode and status bit positions.
`define B_IGN_CBR 0
`define B_IGN_RAW 1
`define B_CC_STORE 2
`define B_PKT 0
`define B_CBR 1
`define B_RAW 2
`define MASK_RST 3'h7
`define MODE_RST 3'h0
// Reassembly entry encodings.
`define ENC_AAL34 16'h0000
`define ENC_AAL5 16'h2000
`define ENC_CBR 16'hC000
`define ENC_RAW 16'hE000
// Descriptor error codes, don't-care bits as zero.
`define ST_PARITY 6'h10
`define ST_OOS 6'h03
`define ST_BADLEN 6'h05
`define ST_CELLCRC 6'h09
`define ST_PKTCRC 6'h08
`define ST_SHORT 6'h21
`define ST_NEWPKT 6'h20
`define ST_OVF_LAST 6'h02
`define ST_OVF_EARLY 6'h22
`define ST_AGED 6'h04
// Exception codes.
`define EXC_INVALID 2'h1
`define EXC_OOS 2'h2
`define EXC_NOBUF 2'h3
// Congestion notification channel and OAM F5 payload types.
`define CC_VCI 16'h0007
`define PT_F5_SEG 3'h4
`define PT_F5_E2E 3'h5
`define Q_DEPTH 16
`endif

// >>> src/reasm_pkg.sv
package reasm_pkg;
  typedef struct packed {
    logic [3:0] gfc;
    logic [7:0] vpi;
    logic [15:0] vci;
    logic [2:0] pt;
    logic clp;
  } hdr_t;
  typedef struct packed {
    hdr_t hdr;
    logic [1:0] seg;
    logic [9:0] mid;
    logic [15:0] ba_size;
    logic last;
    logic parity_err;
    logic crc_err;
    logic len_err;
    logic short_cell;
    logic pkt_crc_err;
    logic ovf;
  } cell_t;
  typedef struct packed {
    logic [5:0] status;
    logic [15:0] vc;
    logic [9:0] vpi_mid;
    logic [12:0] num;
    logic [7:0] cells;
  } desc_t;
  typedef enum logic [1:0] {
    K_AAL34 = 2'b00,
    K_AAL5 = 2'b01,
    K_CBR = 2'b10,
    K_RAW = 2'b11
  } kind_t;
  typedef enum logic {
    S_IDLE = 1'b0,
    S_ROUTE = 1'b1
  } state_t;
  typedef enum logic [1:0] {
    D_NONE = 2'b00,
    D_CBR = 2'b01,
    D_RAW = 2'b10
  } dest_t;
endpackage

// >>> src/ring_track.sv
`timescale 1ns/1ps
`include "reasm_consts.svh"
// Tracks occupancy of one circular queue held outside the block.
module ring_track (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic ign_full,
  output logic empty,
  output logic full,
  output logic [3:0] wr_idx
);
  logic [4:0] count;
  // ===========================================
  // Pointer and count.
  // With the full check ignored a push lands on the oldest entry,
  // so the count saturates instead of wrapping.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 5'h00;
      wr_idx <= 4'h0;
    end else if (ce) begin
      if (push && (!full || ign_full)) begin
        wr_idx <= wr_idx + 4'h1;
        if (!full && !(pop && !empty)) begin
          count <= count + 5'h01;
        end
      end else if (pop && !empty) begin
        count <= count - 5'h01;
      end
    end
  end
  assign empty = (count == 5'h00);
  assign full = (count == 5'(`Q_DEPTH));
endmodule // ring_track

// >>> src/cell_reassembly.sv
`timescale 1ns/1ps
`include "reasm_consts.svh"
// Summary of operation
// - Idle cells dropped, never counted.
// - Congestion cells go to companion; store optional.
// - OAM F5 cells enter raw queue regardless of lookup; dropped when full unless ignored.
// - Filter VPI; invalid lookup discards, raises exception.
// - Valid lookup steers CBR, raw or reassembly.
// - Pick free queue by AAL and threshold.
// - Finished or failed packet posts descriptor number.
// - Complete queue empty-to-nonempty sets packet interrupt.
// - Descriptor holds status, VC, VPI or MID.
// - Low six status bits, zero means clean.
// - Codes for parity, sequence and length errors.
// - Codes for cell CRC, packet CRC, short cell.
// - Codes for new packet and buffer overflows.
// - Aging termination marks its own code.
// - CBR cell stored, pointer advanced, flag set if queue was empty.
// - Full CBR queue drops and counts, unless ignored.
// - Stored congestion cell advances raw queue, flag set if it was empty.
// - Drop congestion cell on full or busy companion.
// - Ignoring raw full overwrites the oldest cells.
// - Exception on orphan COM/EOM or no buffer.
// - Repeat orphan reports suppressed per VC.
// - Entry encodings select AAL3/4, AAL5, CBR, raw.
// - Masks reset to ones; cleared bit enables.
module cell_reassembly
  import reasm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire cell_t cell_in,
  input wire logic cell_valid,
  output logic cell_ready,
  input wire logic cc_ready,
  output logic cc_valid,
  output hdr_t cc_info,
  output logic store_valid,
  output dest_t store_dest,
  output logic [3:0] store_idx,
  output hdr_t store_hdr,
  input wire logic free_small_ok,
  input wire logic free_large_ok,
  input wire logic [12:0] free_small_num,
  input wire logic [12:0] free_large_num,
  output logic take_small,
  output logic take_large,
  output logic done_valid,
  output desc_t done_desc,
  output logic exc_valid,
  output logic [15:0] exc_vc,
  output logic [1:0] exc_code,
  output logic irq
);
  // ===========================================
  // Decoders.
  function automatic kind_t kind_of(input logic [15:0] enc);
    kind_t k;
    k = K_AAL34;
    if (enc == `ENC_AAL5) begin
      k = K_AAL5;
    end else if (enc == `ENC_CBR) begin
      k = K_CBR;
    end else if (enc == `ENC_RAW) begin
      k = K_RAW;
    end
    return k;
  endfunction
  function automatic logic [5:0] errs_of(input cell_t c);
    logic [5:0] s;
    s = 6'h00;
    if (c.len_err) begin
      s = `ST_BADLEN;
    end else if (c.crc_err) begin
      s = `ST_CELLCRC;
    end else if (c.pkt_crc_err) begin
      s = `ST_PKTCRC;
    end else if (c.short_cell) begin
      s = `ST_SHORT;
    end else if (c.ovf) begin
      s = c.last ? `ST_OVF_LAST : `ST_OVF_EARLY;
    end
    if (c.parity_err) begin
      s = s | `ST_PARITY;
    end
    return s;
  endfunction

  // ===========================================
  // Register bus.
  logic [2:0] mode;
  logic [15:0] thresh;
  logic [2:0] status;
  logic [2:0] mask;
  logic [15:0] cbr_drop;
  logic [7:0] vp_filter;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic aw_h;
  logic w_h;
  logic wr_go;
  logic [2:0] pop_req;
  logic age_go;
  logic [3:0] age_idx;
  logic lk_go;
  logic [3:0] lk_idx;
  logic lk_ok;
  logic [15:0] lk_enc;
  logic [2:0] set_st;
  logic cbr_drop_inc;
  logic [3:0] q_empty;
  logic [3:0] q_full;
  logic [3:0] q_push;
  logic [15:0] q_wr;
  logic wstrb_q;
  logic [3:0] pop_all;
  assign wr_go = aw_h && w_h && !bvalid;
  // The spare tracker never pops; padding keeps every index in range.
  assign pop_all = {1'b0, pop_req};
  // Address and data are caught independently; the write lands once both are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_h <= 1'b1;
        aw_q <= awaddr[7:0];
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_h <= 1'b1;
        w_q <= wdata;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= (aw_q > `OFS_VP_FILTER || aw_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_h <= 1'b0;
        w_h <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end
  // Register writes; byte 0 strobe gates every field.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `MODE_RST;
      thresh <= 16'h0000;
      mask <= `MASK_RST;
      vp_filter <= 8'h00;
      pop_req <= 3'h0;
      age_go <= 1'b0;
      age_idx <= 4'h0;
      lk_go <= 1'b0;
      lk_idx <= 4'h0;
      lk_ok <= 1'b0;
      lk_enc <= 16'h0000;
    end else if (ce) begin
      pop_req <= 3'h0;
      age_go <= 1'b0;
      lk_go <= 1'b0;
      if (wr_go && wstrb_q) begin
        if (aw_q == `OFS_MODE) begin
          mode <= w_q[2:0];
        end else if (aw_q == `OFS_THRESH) begin
          thresh <= w_q[15:0];
        end else if (aw_q == `OFS_MASK) begin
          mask <= w_q[2:0];
        end else if (aw_q == `OFS_POP) begin
          pop_req <= w_q[2:0];
        end else if (aw_q == `OFS_LOOKUP) begin
          lk_go <= 1'b1;
          lk_idx <= w_q[3:0];
          lk_ok <= w_q[4];
          lk_enc <= w_q[31:16];
        end else if (aw_q == `OFS_AGE) begin
          age_go <= 1'b1;
          age_idx <= w_q[3:0];
        end else if (aw_q == `OFS_VP_FILTER) begin
          vp_filter <= w_q[7:0];
        end
      end
    end
  end
  // Byte-0 strobe is caught with the data it qualifies.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb_q <= 1'b0;
    end else if (ce && wvalid && wready) begin
      wstrb_q <= wstrb[0];
    end
  end
  // Sticky status, write one to clear; a set in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 3'h0;
    end else if (ce) begin
      if (wr_go && wstrb_q && aw_q == `OFS_STATUS) begin
        status <= (status & ~w_q[2:0]) | set_st;
      end else begin
        status <= status | set_st;
      end
    end
  end
  // Interrupt only for status bits whose mask bit is zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status & ~mask);
    end
  end
  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= 2'h0;
        rdata <= 32'h0000_0000;
        if (araddr[7:0] == `OFS_MODE) begin
          rdata[2:0] <= mode;
        end else if (araddr[7:0] == `OFS_THRESH) begin
          rdata[15:0] <= thresh;
        end else if (araddr[7:0] == `OFS_STATUS) begin
          rdata[2:0] <= status;
        end else if (araddr[7:0] == `OFS_MASK) begin
          rdata[2:0] <= mask;
        end else if (araddr[7:0] == `OFS_CBR_DROP) begin
          rdata[15:0] <= cbr_drop;
        end else if (araddr[7:0] == `OFS_POP) begin
          rdata[3:0] <= q_empty;
        end else if (araddr[7:0] == `OFS_VP_FILTER) begin
          rdata[7:0] <= vp_filter;
        end else if (araddr[7:0] != `OFS_LOOKUP && araddr[7:0] != `OFS_AGE) begin
          rresp <= 2'h2;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ===========================================
  // Queue trackers: CBR, raw, packet complete, spare.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_q
      ring_track u_q (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .push(q_push[gi]),
        .pop(pop_all[gi]),
        .ign_full(gi == 0 ? mode[`B_IGN_CBR] : (gi == 1 ? mode[`B_IGN_RAW] : 1'b0)),
        .empty(q_empty[gi]),
        .full(q_full[gi]),
        .wr_idx(q_wr[gi*4 +: 4])
      );
    end
  endgenerate

  // ===========================================
  // Lookup table and per-VC reassembly context.
  logic lk_valid [16];
  logic [15:0] lk_type [16];
  logic busy [16];
  logic reported [16];
  desc_t ctx [16];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        lk_valid[i] <= 1'b0;
        lk_type[i] <= `ENC_AAL34;
      end
    end else if (ce && lk_go) begin
      lk_valid[lk_idx] <= lk_ok;
      lk_type[lk_idx] <= lk_enc;
    end
  end

  // ===========================================
  // Cell routing, one cell in flight at a time.
  state_t state;
  cell_t cq;
  logic [3:0] vx;
  kind_t kd;
  logic cc_cell;
  logic ok_cbr;
  logic ok_raw;
  logic use_small;
  logic f5_cell;
  assign vx = cq.hdr.vci[3:0];
  // Maintenance cells go to the raw queue whatever their lookup says.
  assign f5_cell = cq.hdr.pt == `PT_F5_SEG || cq.hdr.pt == `PT_F5_E2E;
  assign kd = kind_of(lk_type[vx]);
  assign cc_cell = cq.hdr.vci == `CC_VCI && cq.hdr.vpi == 8'h00;
  assign ok_cbr = !q_full[0] || mode[`B_IGN_CBR];
  assign ok_raw = !q_full[1] || mode[`B_IGN_RAW];
  assign use_small = cq.ba_size <= thresh;
  assign q_push[0] = state == S_ROUTE && cq.hdr != '0 && !cc_cell && !f5_cell && lk_valid[vx]
                     && cq.hdr.vpi == vp_filter && kd == K_CBR && ok_cbr;
  assign q_push[3] = 1'b0;
  assign set_st[`B_CBR] = q_push[0] && q_empty[0];
  assign set_st[`B_RAW] = q_push[1] && q_empty[1];
  assign set_st[`B_PKT] = q_push[2] && q_empty[2];
  assign cbr_drop_inc = state == S_ROUTE && cq.hdr != '0 && !cc_cell && !f5_cell
                        && lk_valid[vx] && cq.hdr.vpi == vp_filter && kd == K_CBR
                        && !ok_cbr;
  logic raw_now;
  always_comb begin
    raw_now = 1'b0;
    if (state == S_ROUTE && cq.hdr != '0 && ok_raw) begin
      if (cc_cell) begin
        raw_now = mode[`B_CC_STORE] && cc_ready;
      end else if (cq.hdr.pt == `PT_F5_SEG || cq.hdr.pt == `PT_F5_E2E) begin
        raw_now = 1'b1;
      end else if (lk_valid[vx] && cq.hdr.vpi == vp_filter) begin
        raw_now = kd == K_RAW;
      end
    end
  end
  assign q_push[1] = raw_now;
  // Accept only when idle, so each cell is routed before the next.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      cell_ready <= 1'b1;
      cq <= '0;
    end else if (ce) begin
      if (state == S_IDLE && cell_valid && cell_ready) begin
        state <= S_ROUTE;
        cell_ready <= 1'b0;
        cq <= cell_in;
      end else if (state == S_ROUTE) begin
        state <= S_IDLE;
        cell_ready <= 1'b1;
      end
    end
  end
  // Idle cells fall through here without touching any counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cbr_drop <= 16'h0000;
    end else if (ce && cbr_drop_inc) begin
      cbr_drop <= cbr_drop + 16'h0001;
    end
  end
  // Store strobes and the congestion hand-off to the companion.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_valid <= 1'b0;
      store_dest <= D_NONE;
      store_idx <= 4'h0;
      store_hdr <= '0;
      cc_valid <= 1'b0;
      cc_info <= '0;
    end else if (ce) begin
      store_valid <= q_push[0] || q_push[1];
      store_dest <= q_push[0] ? D_CBR : (q_push[1] ? D_RAW : D_NONE);
      store_idx <= q_push[0] ? q_wr[3:0] : q_wr[7:4];
      store_hdr <= cq.hdr;
      cc_valid <= state == S_ROUTE && cc_cell && cc_ready && ok_raw;
      cc_info <= cq.hdr;
    end
  end
  // Reassembly: descriptor fetch, completion and exceptions.
  logic seg_start;
  logic seg_end;
  logic reasm;
  assign reasm = state == S_ROUTE && cq.hdr != '0 && !cc_cell && cq.hdr.pt[2] == 1'b0
                 && lk_valid[vx] && cq.hdr.vpi == vp_filter && !kd[1];
  assign seg_start = kd == K_AAL5 ? !busy[vx] : cq.seg[1]; // BOM or SSM
  assign seg_end = kd == K_AAL5 ? cq.last : cq.seg[0]; // EOM or SSM
  logic done_now;
  desc_t d;
  desc_t d_start;
  desc_t d_next;
  logic got;
  assign q_push[2] = done_now;
  // Descriptor of a packet opened now, and the running one after this cell.
  always_comb begin
    d = ctx[vx];
    got = kd == K_AAL5 || !use_small ? free_large_ok : free_small_ok;
    d_start = '0;
    d_start.num = kd == K_AAL5 || !use_small ? free_large_num : free_small_num;
    d_start.vc = cq.hdr.vci;
    d_start.vpi_mid = kd == K_AAL5 ? {2'b00, cq.hdr.vpi} : cq.mid;
    d_start.status = errs_of(cq);
    d_start.cells = 8'h01;
    d_next = ctx[vx];
    d_next.status = ctx[vx].status | errs_of(cq);
    d_next.cells = ctx[vx].cells + 8'h01;
    done_now = 1'b0;
    if (age_go && busy[age_idx]) begin
      done_now = 1'b1;
    end else if (reasm && seg_start && busy[vx]) begin
      done_now = 1'b1;
    end else if (reasm && busy[vx] && (seg_end || errs_of(cq) != 6'h00)) begin
      done_now = 1'b1;
    end else if (reasm && seg_start && got && (seg_end || d_start.status != 6'h00)) begin
      done_now = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        busy[i] <= 1'b0;
        reported[i] <= 1'b0;
        ctx[i] <= '0;
      end
      done_valid <= 1'b0;
      done_desc <= '0;
      take_small <= 1'b0;
      take_large <= 1'b0;
      exc_valid <= 1'b0;
      exc_vc <= 16'h0000;
      exc_code <= 2'h0;
    end else if (ce) begin
      done_valid <= done_now;
      take_small <= 1'b0;
      take_large <= 1'b0;
      exc_valid <= 1'b0;
      exc_vc <= cq.hdr.vci;
      if (age_go && busy[age_idx]) begin
        busy[age_idx] <= 1'b0;
        done_desc <= ctx[age_idx];
        done_desc.status <= ctx[age_idx].status | `ST_AGED;
      end else if (state == S_ROUTE && cq.hdr != '0 && !cc_cell
                   && cq.hdr.pt[2] == 1'b0
                   && (!lk_valid[vx] || cq.hdr.vpi != vp_filter)) begin
        exc_valid <= 1'b1;
        exc_code <= `EXC_INVALID;
      end else if (reasm && seg_start) begin
        if (busy[vx]) begin
          done_desc <= d;
          done_desc.status <= d.status | `ST_NEWPKT;
          busy[vx] <= 1'b0;
        end else if (!got) begin
          exc_valid <= 1'b1;
          exc_code <= `EXC_NOBUF;
        end else begin
          take_large <= kd == K_AAL5 || !use_small;
          take_small <= kd == K_AAL34 && use_small;
          reported[vx] <= 1'b0;
          if (seg_end || d_start.status != 6'h00) begin
            done_desc <= d_start;
          end else begin
            busy[vx] <= 1'b1;
            ctx[vx] <= d_start;
          end
        end
      end else if (reasm && !busy[vx]) begin
        if (!reported[vx]) begin
          exc_valid <= 1'b1;
          exc_code <= `EXC_OOS;
        end
        reported[vx] <= 1'b1;
      end else if (reasm) begin
        if (seg_end || d_next.status != 6'h00) begin
          done_desc <= d_next;
          busy[vx] <= 1'b0;
        end else begin
          ctx[vx] <= d_next;
        end
      end
    end
  end

  // ===========================================
  // Checks.
  a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    state == S_ROUTE && cq.hdr == '0 && ce && !age_go
    |=> !store_valid && !exc_valid && !done_valid)
    else $error("idle cell produced an action");
  a_f5_raw: assert property (@(posedge aclk) disable iff (!aresetn)
    state == S_ROUTE && ce && cq.hdr != '0 && !cc_cell && cq.hdr.pt == `PT_F5_SEG
    && ok_raw |=> store_valid && store_dest == D_RAW)
    else $error("F5 cell not stored in raw queue");
  a_cc_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    state == S_ROUTE && ce && cc_cell && !cc_ready |=> !cc_valid && !store_valid)
    else $error("congestion cell passed while companion busy");
  a_cbr_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cbr_drop_inc |=> cbr_drop == $past(cbr_drop) + 16'h0001 && !store_valid)
    else $error("full CBR queue did not drop and count");
  a_mask_rst: assert property (@(posedge aclk)
    !aresetn |=> mask == `MASK_RST && !irq)
    else $error("mask not all ones after reset");
  a_pkt_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && q_push[2] && q_empty[2] |=> status[`B_PKT])
    else $error("packet flag not set on first completion");
  a_one_cell: assert property (@(posedge aclk) disable iff (!aresetn)
    state == S_ROUTE |-> !cell_ready)
    else $error("cell accepted while routing");
  a_invalid_exc: assert property (@(posedge aclk) disable iff (!aresetn)
    state == S_ROUTE && ce && cq.hdr != '0 && !cc_cell && cq.hdr.pt[2] == 1'b0
    && !lk_valid[vx] && !age_go |=> exc_valid && exc_code == `EXC_INVALID && !store_valid)
    else $error("invalid connection not reported");
  c_cbr: cover property (@(posedge aclk) store_valid && store_dest == D_CBR);
  c_done: cover property (@(posedge aclk) done_valid);
  c_exc: cover property (@(posedge aclk) exc_valid && exc_code == `EXC_OOS);
endmodule // cell_reassembly

// >>> dv/companion_model.sv
`timescale 1ns/1ps
// ==========
// Companion transmit device and free descriptor supply.
module companion_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic busy,
  input wire logic take_small,
  input wire logic take_large,
  output logic cc_ready,
  output logic free_small_ok,
  output logic free_large_ok,
  output logic [12:0] free_small_num,
  output logic [12:0] free_large_num
);
  // The companion refuses congestion info while busy.
  assign cc_ready = ~busy;
  // Software keeps both pools stocked by returning descriptors.
  assign free_small_ok = 1'b1;
  assign free_large_ok = 1'b1;
  // Each take moves on to the next descriptor of that pool.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_small_num <= 13'h0010;
      free_large_num <= 13'h0100;
    end else begin
      free_small_num <= free_small_num + {12'h000, take_small};
      free_large_num <= free_large_num + {12'h000, take_large};
    end
  end
endmodule // companion_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
// ==========
// Cell routing bench.
module testbench;
  import reasm_pkg::*;
  typedef struct packed {logic [7:0] p; logic [15:0] v; logic [2:0] t; logic [4:0] e;} row_t;
  logic aclk = 0, aresetn = 0, busy = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, cell_valid = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd;
  logic [1:0] rr;
  logic [4:0] got;
  cell_t cell_in = '0, c;
  wire awready, wready, bvalid, arready, rvalid, cell_ready, cc_ready, cc_valid, store_valid;
  wire take_small, take_large, done_valid, exc_valid, irq, free_small_ok, free_large_ok;
  wire [1:0] bresp, rresp, exc_code;
  wire [31:0] rdata;
  wire [3:0] store_idx;
  wire [15:0] exc_vc;
  wire [12:0] free_small_num, free_large_num;
  hdr_t cc_info, store_hdr;
  dest_t store_dest;
  desc_t done_desc;
  int fails = 0, tests_run = 0, cyc = 0;
  row_t rows [8];
  // Clock at 250 MHz.
  initial begin
    forever #2 aclk = ~aclk;
  end
  cell_reassembly dut_u (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .cell_in, .cell_valid, .cell_ready, .cc_ready, .cc_valid,
    .cc_info, .store_valid, .store_dest, .store_idx, .store_hdr, .free_small_ok, .free_large_ok,
    .free_small_num, .free_large_num, .take_small, .take_large, .done_valid, .done_desc,
    .exc_valid, .exc_vc, .exc_code, .irq);
  companion_model partner_u (.aclk, .aresetn, .busy, .take_small, .take_large, .cc_ready,
    .free_small_ok, .free_large_ok, .free_small_num, .free_large_num);
  // ==========
  // Shared tasks.
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task give_verdict;
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Address and data are released one by one as each is taken.
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        bready <= 0;
        break;
      end
    end
  endtask
  task rdt(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        rready <= 0;
        rd = rdata;
        rr = rresp;
        break;
      end
    end
  endtask
  function cell_t mk(input logic [7:0] p, input logic [15:0] v, input logic [2:0] t);
    mk = '0;
    mk.hdr.vpi = p;
    mk.hdr.vci = v;
    mk.hdr.pt = t;
    mk.last = 1'b1;
  endfunction
  // Results pulse for one cycle, from the edge after the one that takes the cell.
  task send(input cell_t x);
    @(posedge aclk);
    cell_in <= x;
    cell_valid <= 1;
    forever begin
      @(posedge aclk);
      if (cell_ready) begin
        cell_valid <= 0;
        break;
      end
    end
    @(posedge aclk);
    #1;
    got = {store_valid, store_valid & (store_dest === D_RAW), cc_valid, exc_valid, done_valid};
  endtask
  // A hang counts as a mismatch.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end
  // ==========
  // Main sequence: rows are vpi, vci, pt, then store, raw, companion, exception, done.
  initial begin
    rows = '{'{8'h00, 16'h0000, 3'h0, 5'b00000}, '{8'h00, 16'h0007, 3'h0, 5'b11100},
      '{8'h01, 16'h0009, 3'h4, 5'b11000}, '{8'h02, 16'h0001, 3'h0, 5'b00010},
      '{8'h01, 16'h0004, 3'h0, 5'b00010}, '{8'h01, 16'h0001, 3'h0, 5'b10000},
      '{8'h01, 16'h0002, 3'h0, 5'b11000}, '{8'h01, 16'h0003, 3'h0, 5'b00001}};
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rdt(32'h0000000C);
    chk("mask", 32'h00000007, rd);
    wr(32'h00000020, 32'h00000001);
    wr(32'h00000018, 32'hC0000011);
    wr(32'h00000018, 32'hE0000012);
    wr(32'h00000018, 32'h20000013);
    wr(32'h00000018, 32'h00000004);
    wr(32'h00000000, 32'h00000004);
    foreach (rows[i]) begin
      send(mk(rows[i].p, rows[i].v, rows[i].t));
      chk("route", {27'h0, rows[i].e}, {27'h0, got});
    end
    // A packet CRC failure still completes, with its code.
    c = mk(8'h01, 16'h0003, 3'h0);
    c.pkt_crc_err = 1'b1;
    send(c);
    chk("take", 32'h1, {31'h0, take_large});
    chk("status", 32'h08, {26'h0, done_desc.status});
    chk("vc", 32'h0003, {16'h0, done_desc.vc});
    chk("num", 32'h101, {19'h0, done_desc.num});
    rdt(32'h00000040);
    chk("resp", 32'h2, {30'h0, rr});
    rdt(32'h00000008);
    chk("flags", 32'h7, rd);
    chk("irq", 32'h0, {31'h0, irq});
    wr(32'h0000000C, 32'h00000000);
    rdt(32'h00000008);
    chk("irq", 32'h1, {31'h0, irq});
    wr(32'h00000008, 32'h00000007);
    rdt(32'h00000008);
    chk("irq", 32'h0, {31'h0, irq});
    // A busy companion drops the congestion cell.
    @(posedge aclk) busy <= 1;
    send(mk(8'h00, 16'h0007, 3'h0));
    chk("busy", 32'h0, {27'h0, got});
    @(posedge aclk) busy <= 0;
    // Fill the CBR queue past its depth, then ignore full.
    repeat (16) send(mk(8'h01, 16'h0001, 3'h0));
    chk("full", 32'h0, {27'h0, got});
    rdt(32'h00000010);
    chk("drops", 32'h1, rd);
    wr(32'h00000000, 32'h00000005);
    send(mk(8'h01, 16'h0001, 3'h0));
    chk("ignore", 32'h10, {27'h0, got});
    chk("slot", 32'h0, {28'h0, store_idx});
    chk("hdr", 32'h00100010, store_hdr);
    // A continuation cell with nothing open is reported once per VC.
    wr(32'h00000018, 32'h00000015);
    send(mk(8'h01, 16'h0005, 3'h0));
    chk("oos", 32'h20005, {14'h0, exc_code, exc_vc});
    send(mk(8'h01, 16'h0005, 3'h0));
    chk("repeat", 32'h0, {27'h0, got});
    give_verdict;
  end
endmodule // testbench
